// File: inc/pcs_pkg.sv
package pcs_pkg;

  // register indices, one byte each
  localparam logic [4:0] REG_FRAC_HI = 5'h00;
  localparam logic [4:0] REG_FRAC_MID = 5'h02;
  localparam logic [4:0] REG_FRAC_INT = 5'h04;
  localparam logic [4:0] REG_INT_PRE = 5'h06;
  localparam logic [4:0] REG_PRE_MID = 5'h08;
  localparam logic [4:0] REG_PRE_FB = 5'h0A;
  localparam logic [4:0] REG_FB_MID = 5'h0C;
  localparam logic [4:0] REG_FB_OUT = 5'h0E;
  localparam logic [4:0] REG_OUT_BW = 5'h10;
  localparam logic [4:0] REG_BW_TYPE = 5'h12;
  localparam logic [4:0] REG_MODE_OE = 5'h14;
  localparam logic [4:0] REG_INSEL = 5'h15;
  localparam logic [4:0] REG_DOUBLER = 5'h16;
  localparam logic [4:0] REG_STATUS = 5'h17;

  // fixed bit patterns of the mixed registers
  localparam logic [7:0] MODE_OE_FIXED = 8'h10;
  localparam logic [7:0] DOUBLER_FIXED = 8'hA1;
  localparam int DOUBLER_BIT = 3;

  // input selection policy codes
  localparam logic [1:0] POL_MAN_PIN = 2'h0;
  localparam logic [1:0] POL_AUTO_NONREV = 2'h1;
  localparam logic [1:0] POL_AUTO_REV = 2'h2;
  localparam logic [1:0] POL_MAN_REG = 2'h3;

  // normalised operating modes
  typedef enum logic [1:0] {PCS_LOW_BW, PCS_SYNTH, PCS_HIGH_BW} pcs_mode_t;

  // timing
  localparam int CLK_MHZ = 50;
  localparam int LCK_WIN_BASE_US = 2;
  localparam int LCK_WIN_BASE_CYC = LCK_WIN_BASE_US * CLK_MHZ;
  localparam int ADC_DIV_BASE = 16;

  typedef struct packed {
    logic [17:0] upper_fb_frac_part;
    logic [7:0] upper_fb_int_part;
    logic [16:0] ref_prediv;
    logic [16:0] lower_loop_fb_div;
    logic [10:0] output_divider;
    logic [6:0] loop_settings;
    logic out1_signal_type;
    logic out0_signal_type;
    logic [1:0] pll_operating_mode;
    logic out1_enable;
    logic out0_enable;
    logic input_select_bit;
    logic [1:0] input_select_policy;
    logic [1:0] adc_sample_rate;
    logic [1:0] lock_window_width;
    logic ref_doubler_enable;
  } pcs_cfg_t;

  typedef struct packed {
    logic active_input_flag;
    logic holdover_flag;
    logic input1_fault_flag;
    logic input0_fault_flag;
    logic ref_fault_flag;
    logic locked_flag;
  } pcs_stat_t;

  typedef struct packed {
    pcs_mode_t op_mode;
    logic [4:0] adc_ref_div;
    logic [10:0] lock_win_cycles;
    logic [1:0] pfd_ref_mult;
  } pcs_ctl_t;

  // values after reset
  localparam pcs_cfg_t PCS_CFG_RST = '0;
  localparam pcs_stat_t PCS_STAT_RST = '0;
  localparam pcs_ctl_t PCS_CTL_RST = '{PCS_LOW_BW, 5'h10, 11'h064, 2'h1};

endpackage

// File: verilog/pcs_field_bank.sv
`timescale 1ns/100ps
// Overview of operation
// - one type bit per output pair: 0 selects LVPECL, 1 selects LVDS
// - 17-bit reference pre-divider and 11-bit output divider applied to paths
// - 17-bit integer feedback divider for the lower loop
// - 8-bit integer part of the upper loop feedback divider
// - 18-bit fractional part combined with the upper loop integer part
// - 7-bit loop settings whose meaning depends on the operating mode
// - mode field: 00 low bandwidth, 01 synthesis, 10 and 11 high bandwidth
// - each output pair has an enable bit, 1 enables
// - policy: 00 pin manual, 01 auto non-revertive, 10 auto revertive, 11 register
// - register manual: select bit 0 picks input 0, 1 picks input 1
// - auto revertive: select bit names the primary; auto non-revertive and pin manual: bit ignored
// - ADC rate codes give reference divided by 16, 8, 4 or 2
// - lock window codes give 2, 4, 8 or 16 us
// - doubler bit doubles reference before the phase detector
// - one self-clearing bad flag per input clock
// - reference fault flag follows the reference state
// - lock bit mirrors loop lock and drives the lock pin
// - holdover flag set while phase detector input is out of spec
// - active input flag follows automatic fail-over
// - disabled output pair is high impedance
module pcs_field_bank
  import pcs_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // monitor and loop pins
  input wire logic in0_bad_pin,
  input wire logic in1_bad_pin,
  input wire logic ref_bad_pin,
  input wire logic loop_lock_pin,
  input wire logic loop_holdover_pin,
  input wire logic input_select_pin,
  // configuration towards the analog core
  output pcs_cfg_t cfg,
  output pcs_ctl_t ctl,
  output pcs_stat_t stat,
  // output pair drivers and lock pin
  output logic out0_drive_en,
  output logic out1_drive_en,
  output logic out0_lvds_sel,
  output logic out1_lvds_sel,
  output logic lock_pin
);

  pcs_cfg_t cfg_r;
  pcs_ctl_t ctl_r;
  pcs_stat_t stat_r;
  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic active_nxt;
  logic out0_en_r;
  logic out1_en_r;
  logic out0_lvds_r;
  logic out1_lvds_r;
  logic lock_pin_r;
  logic in0_fault_r;
  logic in1_fault_r;
  logic ref_fault_r;
  logic locked_r;
  logic holdover_r;
  logic active_r;

  logic s_in0_bad;
  logic s_in1_bad;
  logic s_ref_bad;
  logic s_lock;
  logic s_hold;
  logic s_sel_pin;

  // two-stage synchroniser for the pins
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pin_meta_r <= 6'h00;
      pin_sync_r <= 6'h00;
    end
    else if (clk_en)
    begin
      pin_meta_r <= {input_select_pin, loop_holdover_pin, loop_lock_pin,
                     ref_bad_pin, in1_bad_pin, in0_bad_pin};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign s_in0_bad = pin_sync_r[0];
  assign s_in1_bad = pin_sync_r[1];
  assign s_ref_bad = pin_sync_r[2];
  assign s_lock = pin_sync_r[3];
  assign s_hold = pin_sync_r[4];
  assign s_sel_pin = pin_sync_r[5];

  // host writes into configuration fields; reserved positions are dropped
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cfg_r <= PCS_CFG_RST;
    end
    else if (clk_en && reg_wr)
    begin
      case (reg_addr)
        REG_FRAC_HI:
        begin
          cfg_r.upper_fb_frac_part[17:10] <= reg_wdata;
        end
        REG_FRAC_MID:
        begin
          cfg_r.upper_fb_frac_part[9:2] <= reg_wdata;
        end
        REG_FRAC_INT:
        begin
          cfg_r.upper_fb_frac_part[1:0] <= reg_wdata[7:6];
          cfg_r.upper_fb_int_part[7:2] <= reg_wdata[5:0];
        end
        REG_INT_PRE:
        begin
          cfg_r.upper_fb_int_part[1:0] <= reg_wdata[7:6];
          cfg_r.ref_prediv[16:11] <= reg_wdata[5:0];
        end
        REG_PRE_MID:
        begin
          cfg_r.ref_prediv[10:3] <= reg_wdata;
        end
        REG_PRE_FB:
        begin
          cfg_r.ref_prediv[2:0] <= reg_wdata[7:5];
          cfg_r.lower_loop_fb_div[16:12] <= reg_wdata[4:0];
        end
        REG_FB_MID:
        begin
          cfg_r.lower_loop_fb_div[11:4] <= reg_wdata;
        end
        REG_FB_OUT:
        begin
          cfg_r.lower_loop_fb_div[3:0] <= reg_wdata[7:4];
          cfg_r.output_divider[10:7] <= reg_wdata[3:0];
        end
        REG_OUT_BW:
        begin
          cfg_r.output_divider[6:0] <= reg_wdata[7:1];
          cfg_r.loop_settings[6] <= reg_wdata[0];
        end
        REG_BW_TYPE:
        begin
          cfg_r.loop_settings[5:0] <= reg_wdata[7:2];
          cfg_r.out1_signal_type <= reg_wdata[1];
          cfg_r.out0_signal_type <= reg_wdata[0];
        end
        REG_MODE_OE:
        begin
          cfg_r.pll_operating_mode <= reg_wdata[7:6];
          cfg_r.out1_enable <= reg_wdata[3];
          cfg_r.out0_enable <= reg_wdata[2];
        end
        REG_INSEL:
        begin
          cfg_r.input_select_bit <= reg_wdata[7];
          cfg_r.input_select_policy <= reg_wdata[6:5];
          cfg_r.adc_sample_rate <= reg_wdata[3:2];
          cfg_r.lock_window_width <= reg_wdata[1:0];
        end
        REG_DOUBLER:
        begin
          cfg_r.ref_doubler_enable <= reg_wdata[DOUBLER_BIT];
        end
        default:
        begin
          // status and reserved registers hold no writable state
          cfg_r <= cfg_r;
        end
      endcase
    end
  end

  // derived controls for the analog loop
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctl_r <= PCS_CTL_RST;
    end
    else if (clk_en)
    begin
      case (cfg_r.pll_operating_mode)
        2'h0: ctl_r.op_mode <= PCS_LOW_BW;
        2'h1: ctl_r.op_mode <= PCS_SYNTH;
        default: ctl_r.op_mode <= PCS_HIGH_BW;
      endcase
      // divide ratio 16 >> code
      ctl_r.adc_ref_div <= 5'(ADC_DIV_BASE >> cfg_r.adc_sample_rate);
      // window 2 us << code, in clock cycles
      ctl_r.lock_win_cycles <=
        11'(LCK_WIN_BASE_CYC << cfg_r.lock_window_width);
      ctl_r.pfd_ref_mult <= cfg_r.ref_doubler_enable ? 2'h2 : 2'h1;
    end
  end

  // active input choice and fail-over
  always_comb
  begin
    active_nxt = stat_r.active_input_flag;
    case (cfg_r.input_select_policy)
      POL_MAN_PIN:
      begin
        active_nxt = s_sel_pin;
      end
      POL_MAN_REG:
      begin
        active_nxt = cfg_r.input_select_bit;
      end
      POL_AUTO_NONREV:
      begin
        // stay put unless the active input fails and the other is good
        if (stat_r.active_input_flag ? (s_in1_bad && !s_in0_bad)
                                     : (s_in0_bad && !s_in1_bad))
        begin
          active_nxt = !stat_r.active_input_flag;
        end
      end
      POL_AUTO_REV:
      begin
        // return to the primary whenever it is good
        if (cfg_r.input_select_bit ? !s_in1_bad : !s_in0_bad)
        begin
          active_nxt = cfg_r.input_select_bit;
        end
        else if (cfg_r.input_select_bit ? !s_in0_bad : !s_in1_bad)
        begin
          active_nxt = !cfg_r.input_select_bit;
        end
      end
      default:
      begin
        active_nxt = stat_r.active_input_flag;
      end
    endcase
  end

  // status packed from its own flops; host writes never reach them
  assign stat_r = {active_r, holdover_r, in1_fault_r, in0_fault_r, ref_fault_r, locked_r};

  // fault flags clear as soon as the monitor does
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      in0_fault_r <= PCS_STAT_RST.input0_fault_flag;
      in1_fault_r <= PCS_STAT_RST.input1_fault_flag;
      ref_fault_r <= PCS_STAT_RST.ref_fault_flag;
    end
    else if (clk_en)
    begin
      in0_fault_r <= s_in0_bad;
      in1_fault_r <= s_in1_bad;
      ref_fault_r <= s_ref_bad;
    end
  end

  // loop lock and holdover; lock pin mirrors the lock flag
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      locked_r <= PCS_STAT_RST.locked_flag;
      holdover_r <= PCS_STAT_RST.holdover_flag;
      lock_pin_r <= 1'b0;
    end
    else if (clk_en)
    begin
      locked_r <= s_lock;
      holdover_r <= s_hold;
      lock_pin_r <= s_lock;
    end
  end

  // active input, moved by policy or fail-over
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      active_r <= PCS_STAT_RST.active_input_flag;
    end
    else if (clk_en)
    begin
      active_r <= active_nxt;
    end
  end

  // pair drivers; low enable leaves the pair floating
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      out0_en_r <= 1'b0;
      out1_en_r <= 1'b0;
    end
    else if (clk_en)
    begin
      out0_en_r <= cfg_r.out0_enable;
      out1_en_r <= cfg_r.out1_enable;
    end
  end

  // pair signal type, high for LVDS
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      out0_lvds_r <= 1'b0;
      out1_lvds_r <= 1'b0;
    end
    else if (clk_en)
    begin
      out0_lvds_r <= cfg_r.out0_signal_type;
      out1_lvds_r <= cfg_r.out1_signal_type;
    end
  end

  // read multiplexer; reserved bits read zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      REG_FRAC_HI: rdata_nxt = cfg_r.upper_fb_frac_part[17:10];
      REG_FRAC_MID: rdata_nxt = cfg_r.upper_fb_frac_part[9:2];
      REG_FRAC_INT: rdata_nxt = {cfg_r.upper_fb_frac_part[1:0],
                                 cfg_r.upper_fb_int_part[7:2]};
      REG_INT_PRE: rdata_nxt = {cfg_r.upper_fb_int_part[1:0], cfg_r.ref_prediv[16:11]};
      REG_PRE_MID: rdata_nxt = cfg_r.ref_prediv[10:3];
      REG_PRE_FB: rdata_nxt = {cfg_r.ref_prediv[2:0], cfg_r.lower_loop_fb_div[16:12]};
      REG_FB_MID: rdata_nxt = cfg_r.lower_loop_fb_div[11:4];
      REG_FB_OUT: rdata_nxt = {cfg_r.lower_loop_fb_div[3:0], cfg_r.output_divider[10:7]};
      REG_OUT_BW: rdata_nxt = {cfg_r.output_divider[6:0], cfg_r.loop_settings[6]};
      REG_BW_TYPE: rdata_nxt = {cfg_r.loop_settings[5:0], cfg_r.out1_signal_type,
                                cfg_r.out0_signal_type};
      REG_MODE_OE: rdata_nxt = MODE_OE_FIXED | {cfg_r.pll_operating_mode, 2'h0,
                                                cfg_r.out1_enable, cfg_r.out0_enable,
                                                2'h0};
      REG_INSEL: rdata_nxt = {cfg_r.input_select_bit, cfg_r.input_select_policy, 1'b0,
                              cfg_r.adc_sample_rate, cfg_r.lock_window_width};
      REG_DOUBLER: rdata_nxt = DOUBLER_FIXED |
                               (8'(cfg_r.ref_doubler_enable) << DOUBLER_BIT);
      REG_STATUS: rdata_nxt = {stat_r, 2'h0};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rdata_r <= 8'h00;
    end
    else if (clk_en)
    begin
      rdata_r <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  assign reg_rdata = rdata_r;
  assign cfg = cfg_r;
  assign ctl = ctl_r;
  assign stat = stat_r;
  assign out0_drive_en = out0_en_r;
  assign out1_drive_en = out1_en_r;
  assign out0_lvds_sel = out0_lvds_r;
  assign out1_lvds_sel = out1_lvds_r;
  assign lock_pin = lock_pin_r;

endmodule

// File: test/pcs_chk.sv
`timescale 1ns/100ps
module pcs_chk
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic in0_bad_pin,
  input wire logic in1_bad_pin,
  input wire logic ref_bad_pin,
  input wire logic loop_lock_pin,
  input wire logic loop_holdover_pin,
  input wire logic input_select_pin,
  // outputs
  input wire pcs_cfg_t cfg,
  input wire pcs_ctl_t ctl,
  input wire pcs_stat_t stat,
  input wire logic out0_drive_en,
  input wire logic out1_drive_en,
  input wire logic out0_lvds_sel,
  input wire logic out1_lvds_sel,
  input wire logic lock_pin
);
  logic [2:0] age_r;
  // edges since reset release, saturating
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      age_r <= 3'h0;
    else if (age_r != 3'h7)
      age_r <= age_r + 3'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_oe;
    {out1_drive_en, out0_drive_en} == $past({cfg.out1_enable, cfg.out0_enable});
  endproperty
  a_oe: assert property (p_oe)
    else $error("pair drive enable differs from enable field");
  property p_type;
    {out1_lvds_sel, out0_lvds_sel} == $past({cfg.out1_signal_type, cfg.out0_signal_type});
  endproperty
  a_type: assert property (p_type)
    else $error("pair signal type differs from type field");
  property p_mode;
    ctl.op_mode == ($past(cfg.pll_operating_mode) == 2'h0 ? PCS_LOW_BW :
      $past(cfg.pll_operating_mode) == 2'h1 ? PCS_SYNTH : PCS_HIGH_BW);
  endproperty
  a_mode: assert property (p_mode)
    else $error("operating mode decode wrong");
  property p_rate;
    ctl.adc_ref_div == 5'h10 >> $past(cfg.adc_sample_rate);
  endproperty
  a_rate: assert property (p_rate)
    else $error("sampling divider wrong");
  property p_win;
    ctl.lock_win_cycles == 11'h064 << $past(cfg.lock_window_width);
  endproperty
  a_win: assert property (p_win)
    else $error("lock window length wrong");
  property p_dbl;
    reg_rd && reg_addr == REG_DOUBLER |=>
      reg_rdata == {4'hA, $past(cfg.ref_doubler_enable), 3'h1} &&
      ctl.pfd_ref_mult == ($past(cfg.ref_doubler_enable) ? 2'h2 : 2'h1);
  endproperty
  a_dbl: assert property (p_dbl)
    else $error("doubler readback or multiplier wrong");
  property p_mon;
    age_r == 3'h7 |-> {stat.input1_fault_flag, stat.input0_fault_flag,
      stat.ref_fault_flag, stat.holdover_flag} ==
      $past({in1_bad_pin, in0_bad_pin, ref_bad_pin, loop_holdover_pin}, 3);
  endproperty
  a_mon: assert property (p_mon)
    else $error("fault or holdover flags do not follow pins");
  property p_lock;
    age_r == 3'h7 |-> lock_pin == $past(loop_lock_pin, 3) && stat.locked_flag == lock_pin;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock flag or lock pin wrong");
  property p_man;
    (age_r == 3'h7 && cfg.input_select_policy == POL_MAN_REG && $stable(cfg))[*3]
      |-> stat.active_input_flag == cfg.input_select_bit;
  endproperty
  a_man: assert property (p_man)
    else $error("register selection not followed");
  property p_pin;
    (age_r == 3'h7 && cfg.input_select_policy == POL_MAN_PIN && $stable(cfg)
      && $stable(input_select_pin))[*5] |-> stat.active_input_flag == input_select_pin;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin selection not followed");
endmodule

bind pcs_field_bank pcs_chk u_chk (.ref_clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata,
  .in0_bad_pin, .in1_bad_pin, .ref_bad_pin, .loop_lock_pin, .loop_holdover_pin,
  .input_select_pin, .cfg, .ctl, .stat, .out0_drive_en, .out1_drive_en,
  .out0_lvds_sel, .out1_lvds_sel, .lock_pin);

// File: test/pcs_host.sv
`timescale 1ns/100ps
module pcs_host
  import pcs_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register port
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // reserved bits up to the status register go out as zero, fixed bits as they read; data above it passes unchanged
  function automatic logic [7:0] fix(input logic [4:0] a, input logic [7:0] d);
    if (a < 5'h14 && a[0])
      return 8'h00;
    if (a == REG_MODE_OE)
      return (d & 8'hCC) | MODE_OE_FIXED;
    if (a == REG_INSEL)
      return d & 8'hEF;
    if (a == REG_DOUBLER)
      return (d & 8'h08) | DOUBLER_FIXED;
    if (a == REG_STATUS)
      return d & 8'hFC;
    return d;
  endfunction
  // strobe stays up until the next transfer or idle
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= fix(a, d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
endmodule

// File: test/pcs_field_bank_tb.sv
`timescale 1ns/100ps
module pcs_field_bank_tb import pcs_pkg::*;;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, sel_pin = 1'b0;
  logic clk_en = 1'b1;
  logic [4:0] pv = 5'h00;
  pcs_cfg_t cfg;
  pcs_ctl_t ctl;
  pcs_stat_t stat;
  logic o0, o1, t0, t1, lock_pin;
  int mdl[32];
  int act, miscompares, compares;
  always #10 ref_clk = ~ref_clk;
  pcs_host u_host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  pcs_field_bank DUT (.ref_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .in0_bad_pin(pv[2]), .in1_bad_pin(pv[3]),
    .ref_bad_pin(pv[1]), .loop_lock_pin(pv[0]), .loop_holdover_pin(pv[4]),
    .input_select_pin(sel_pin), .cfg, .ctl, .stat, .out0_drive_en(o0),
    .out1_drive_en(o1), .out0_lvds_sel(t0), .out1_lvds_sel(t1), .lock_pin);
  task automatic check(input logic [111:0] seen, input logic [111:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [91:0] exp_cfg();
    logic [79:0] lo;
    logic [7:0] a, b, c;
    for (int i = 0; i < 10; i++)
      lo = {lo[71:0], 8'(mdl[2 * i])};
    a = 8'(mdl[20]);
    b = 8'(mdl[21]);
    c = 8'(mdl[22]);
    return {lo, a[7:6], a[3:2], b[7:5], b[3:0], c[3]};
  endfunction
  function automatic logic [19:0] exp_ctl();
    int m = mdl[20] >> 6;
    return {m == 0 ? PCS_LOW_BW : m == 1 ? PCS_SYNTH : PCS_HIGH_BW,
      5'(16 >> ((mdl[21] >> 2) & 3)), 11'(100 << (mdl[21] & 3)), 2'(((mdl[22] >> 3) & 1) + 1)};
  endfunction
  task automatic rd_chk(input int a);
    logic [7:0] d;
    u_host.rd(5'(a), d);
    check(d, a == 23 ? {act[0], pv, 2'h0} : 8'(mdl[a]));
  endtask
  task automatic wrm(input int a, input int v);
    v = u_host.fix(5'(a), 8'(v));
    u_host.wr(5'(a), 8'(v));
    if (a < 23)
      mdl[a] = v;
  endtask
  task automatic step_act();
    int pol = (mdl[21] >> 5) & 3;
    int s = mdl[21] >> 7;
    case (pol)
      0: act = sel_pin;
      3: act = s;
      1: if (pv[2 + act] && !pv[3 - act]) act = 1 - act;
      default: if (!pv[2 + s]) act = s; else if (!pv[3 - s]) act = 1 - s;
    endcase
  endtask
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    summarize();
  end
  initial
  begin
    mdl[20] = 8'h10;
    mdl[22] = 8'hA1;
    void'($urandom(66));
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    check({cfg, ctl}, {exp_cfg(), exp_ctl()});
    for (int a = 0; a < 32; a++)
      rd_chk(a);
    for (int i = 0; i < 80; i++)
    begin
      wrm($urandom_range(31), $urandom);
      u_host.idle(1);
      step_act();
      rd_chk($urandom_range(31));
      check({cfg, ctl}, {exp_cfg(), exp_ctl()});
      check({o1, o0, t1, t0}, {mdl[20][3:2], mdl[18][1:0]});
    end
    clk_en <= 1'b0;
    u_host.wr(REG_FRAC_HI, ~8'(mdl[0]));
    u_host.idle(1);
    clk_en <= 1'b1;
    check({cfg, ctl}, {exp_cfg(), exp_ctl()});
    for (int c = 0; c < 4; c++)
    begin
      wrm(REG_MODE_OE, {2'(c), 6'h0C});
      wrm(REG_INSEL, {1'b0, 2'(c), 1'b0, 2'(c), 2'(c)});
      wrm(REG_DOUBLER, {4'h0, 1'(c), 3'h0});
      u_host.idle(2);
      check({cfg, ctl}, {exp_cfg(), exp_ctl()});
    end
    for (int p = 0; p < 4; p++)
    begin
      wrm(REG_INSEL, {1'($urandom), 2'(p), 5'h08});
      u_host.idle(6);
      step_act();
      for (int i = 0; i < 8; i++)
      begin
        wrm(REG_STATUS, $urandom);
        pv <= 5'($urandom);
        sel_pin <= 1'($urandom);
        u_host.idle(6);
        step_act();
        rd_chk(REG_STATUS);
        check(stat, {act[0], pv});
        check(lock_pin, pv[0]);
      end
    end
    summarize();
  end
endmodule
